// ==== hdl/fsir_seq.sv ====
// filter sequencer with instruction memory and wishbone register slave
`timescale 1ns/100ps
`default_nettype none
`include "fsir_cfg.svh"
module fsir_seq
#(
  parameter logic [3:0] CHANNEL = 4'h0
)
(
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // wishbone slave
  input  wire fsir_pkg::fsir_wb_req_type  wb_req_i,
  output logic                            wb_ack_o,
  output logic [31:0]                     wb_dat_o,
  // compute engine
  input  wire logic                       sample_i,
  input  wire logic                       fir_output_i,
  input  wire logic                       fir_done_i,
  input  wire logic                       resampler_carry_out_i,
  output fsir_pkg::fsir_fir_cmd_type      fir_cmd_o,
  output logic                            resampler_step_o,
  output logic                            data_ptr_reset_o,
  output logic [4:0]                      step_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state and instruction memory
  fsir_pkg::fsir_regs_type  s_reg;
  fsir_pkg::fsir_regs_type  s_next;
  logic [127:0]             mem [0:31];
  logic [127:0]             instr;
  fsir_pkg::fsir_op_type    op;
  logic                     cond_true;

  assign instr = mem[s_reg.pc];

  fsir_op_decode u_dec
  (
    .op_i  (instr[8:0]),
    .dec_o (op)
  );

  fsir_cond u_cond
  (
    .sel_i      (op.condition_select),
    .wait_cnt_i (s_reg.wait_cnt),
    .thresh_i   (s_reg.thresh),
    .loop_cnt_i (s_reg.loop_cnt),
    .rs_carry_i (resampler_carry_out_i),
    .sync_i     (s_reg.sync_bit),
    .true_o     (cond_true)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [15:0]  idx;
  logic         chan_hit;
  logic         reg_hit;
  logic         mem_hit;
  logic         req_new;
  logic         wr_do;
  logic         freset;
  logic [31:0]  rd_mux;

  assign idx = wb_req_i.adr[17:2];
  assign chan_hit = idx[15:12] == CHANNEL;
  assign reg_hit = chan_hit && idx[11:7] == `FSIR_REGION_REGS;
  assign mem_hit = chan_hit && idx[11:7] == `FSIR_REGION_MEM;
  assign req_new = wb_req_i.cyc && wb_req_i.stb && !s_reg.ack;
  // a write lands on the edge at which ack is seen high
  assign wr_do = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && s_reg.ack;
  assign freset = wr_do && reg_hit && idx[6:0] == `FSIR_REG_FRESET && wb_req_i.dat[0];

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (mem_hit && s_reg.host_access_hold)
    begin
      rd_mux = mem[idx[6:2]][{idx[1:0], 5'h00} +: 32];
    end
    else if (reg_hit)
    begin
      unique case (idx[6:0])
        `FSIR_REG_CTRL:   rd_mux = {29'h0, s_reg.sync_bit, s_reg.rs_mode,
                                    s_reg.host_access_hold};
        `FSIR_REG_THRESH: rd_mux = {22'h0, s_reg.thresh};
        `FSIR_REG_DECR:   rd_mux = {6'h00, s_reg.dec_b, 6'h00, s_reg.dec_a};
        `FSIR_REG_OFFSET: rd_mux = {s_reg.off_en, 15'h0000, s_reg.off_val, 3'h0,
                                    s_reg.off_step};
        `FSIR_REG_STATUS: rd_mux = {6'h00, s_reg.wait_cnt, 5'h00, s_reg.state, 3'h0,
                                    s_reg.pc};
        `FSIR_REG_LOOP:   rd_mux = {20'h00000, s_reg.loop_cnt};
        default:          rd_mux = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host quarter writes into the step memory
  always_ff @(posedge clk_i)
  begin
    if (wr_do && mem_hit && s_reg.host_access_hold)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wb_req_i.sel[b])
        begin
          mem[idx[6:2]][{idx[1:0], b[1:0], 3'h0} +: 8] <= wb_req_i.dat[b*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wait count arithmetic
  logic        running;
  logic        fir_go;
  logic [10:0] wc_sum;
  logic [10:0] wc_dec;

  assign running = s_reg.state == fsir_pkg::ST_RUN && !s_reg.host_access_hold && !freset;
  assign fir_go = running && op.kind == fsir_pkg::K_FIR;
  assign wc_sum = {1'b0, s_reg.wait_cnt}
                + {10'h000, sample_i && s_reg.wait_cnt != 10'h3FF};
  // decrement applies as the step begins execution
  assign wc_dec = (fir_go && op.wait_decrement_enable)
                ? {1'b0, op.wait_decrement_choice ? s_reg.dec_b : s_reg.dec_a}
                : 11'h000;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_next = s_reg;
    s_next.ack = req_new;
    s_next.rdat = req_new ? rd_mux : s_reg.rdat;
    s_next.cmd.start = 1'b0;
    s_next.rs_step = 1'b0;
    s_next.ptr_rst = 1'b0;
    s_next.wait_cnt = (wc_sum < wc_dec) ? 10'h000 : 10'(wc_sum - wc_dec);

    if (wr_do && reg_hit)
    begin
      unique case (idx[6:0])
        `FSIR_REG_CTRL:
        begin
          s_next.host_access_hold = wb_req_i.dat[`FSIR_CTRL_HOLD];
          s_next.rs_mode = wb_req_i.dat[`FSIR_CTRL_RSMODE];
          s_next.sync_bit = wb_req_i.dat[`FSIR_CTRL_SYNC];
        end
        `FSIR_REG_THRESH: s_next.thresh = wb_req_i.dat[9:0];
        `FSIR_REG_DECR:
        begin
          s_next.dec_a = wb_req_i.dat[9:0];
          s_next.dec_b = wb_req_i.dat[25:16];
        end
        `FSIR_REG_OFFSET:
        begin
          s_next.off_step = wb_req_i.dat[4:0];
          s_next.off_val = wb_req_i.dat[15:8];
          s_next.off_en = wb_req_i.dat[31];
        end
        default:
        begin
        end
      endcase
    end

    unique case (s_reg.state)
      fsir_pkg::ST_PRIME:
      begin
        if (!s_reg.host_access_hold)
        begin
          s_next.pc = s_reg.pc + 5'h01;
          s_next.state = fsir_pkg::ST_RUN;
        end
      end
      fsir_pkg::ST_RUN:
      begin
        if (running)
        begin
          unique case (op.kind)
            fsir_pkg::K_WAIT:
            begin
              if (cond_true)
              begin
                s_next.pc = s_reg.pc + 5'h01;
              end
            end
            fsir_pkg::K_JUMP:
            begin
              s_next.pc = cond_true ? op.jump_target_field
                                    : s_reg.pc + 5'h01;
            end
            fsir_pkg::K_FIR:
            begin
              if (op.loop_preload_flag)
              begin
                s_next.loop_cnt = instr[20:9];
              end
              else if (op.loop_decrement_flag && s_reg.loop_cnt != 12'h000)
              begin
                s_next.loop_cnt = s_reg.loop_cnt - 12'h001;
              end
              if (op.start)
              begin
                s_next.cmd.start = 1'b1;
                s_next.cmd.param = instr[127:9];
                s_next.cmd.rotation_counter_enable = op.rotation_counter_enable;
                s_next.cmd.read_offset = (s_reg.off_en && s_reg.off_step == s_reg.pc)
                                       ? s_reg.off_val : 8'h00;
                s_next.rs_step = op.resampler_step_flag && !s_reg.rs_mode;
                s_next.rs_arm = op.resampler_step_flag;
                s_next.state = fsir_pkg::ST_BUSY;
              end
              else
              begin
                s_next.pc = s_reg.pc + 5'h01;
              end
            end
            default:
            begin
            end
          endcase
        end
      end
      fsir_pkg::ST_BUSY:
      begin
        s_next.rs_step = fir_output_i && s_reg.rs_arm && s_reg.rs_mode;
        if (fir_done_i)
        begin
          s_next.pc = s_reg.pc + 5'h01;
          s_next.rs_arm = 1'b0;
          s_next.state = fsir_pkg::ST_RUN;
        end
      end
      default:
      begin
        s_next.state = fsir_pkg::ST_PRIME;
      end
    endcase

    if (freset)
    begin
      s_next.pc = `FSIR_LAST_STEP;
      s_next.state = fsir_pkg::ST_PRIME;
      s_next.ptr_rst = 1'b1;
      s_next.rs_arm = 1'b0;
      s_next.cmd.start = 1'b0;
      s_next.rs_step = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      s_reg.state <= fsir_pkg::ST_PRIME;
      s_reg.pc <= `FSIR_LAST_STEP;
      s_reg.ptr_rst <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdat;
  assign fir_cmd_o = s_reg.cmd;
  assign resampler_step_o = s_reg.rs_step;
  assign data_ptr_reset_o = s_reg.ptr_rst;
  assign step_o = s_reg.pc;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_to_last:
    assert property (freset |=> s_reg.pc == 5'h1F && s_reg.state == fsir_pkg::ST_PRIME)
    else $error("filter reset did not park pointer on last step");

  a_prime_wraps_zero:
    assert property (s_reg.state == fsir_pkg::ST_PRIME && s_reg.pc == 5'h1F
                     && !s_reg.host_access_hold && !freset |=> s_reg.pc == 5'h00)
    else $error("pointer did not wrap to step zero after reset");

  a_ptr_reset_pulse:
    assert property (freset |=> data_ptr_reset_o ##1 !data_ptr_reset_o || $past(freset))
    else $error("data pointer reset not pulsed on filter reset");

  a_wait_stalls:
    assert property (running && op.kind == fsir_pkg::K_WAIT && !cond_true |=> $stable(s_reg.pc))
    else $error("wait step advanced with false condition");

  a_jump_lands:
    assert property (running && op.kind == fsir_pkg::K_JUMP
                     |=> s_reg.pc == ($past(cond_true) ? $past(op.jump_target_field)
                                                       : $past(s_reg.pc) + 5'h01))
    else $error("jump landed on wrong step");

  a_loop_preload:
    assert property (fir_go && op.loop_preload_flag |=> s_reg.loop_cnt == $past(instr[20:9]))
    else $error("loop counter not preloaded from step word");

  a_hold_gates_read:
    assert property (req_new && mem_hit && !s_reg.host_access_hold
                     |=> wb_ack_o && wb_dat_o == 32'h00000000)
    else $error("step memory readable without host hold");

  a_start_issues:
    assert property (fir_go && op.start |=> fir_cmd_o.start
                     && s_reg.state == fsir_pkg::ST_BUSY ##1 !fir_cmd_o.start)
    else $error("filter step did not issue one start pulse");

  a_offset_step:
    assert property (fir_cmd_o.start && fir_cmd_o.read_offset != 8'h00
                     |-> s_reg.off_en && s_reg.pc == s_reg.off_step)
    else $error("read offset applied to the wrong step");

  a_decrement_once:
    assert property (fir_go && op.wait_decrement_enable && !sample_i
                     && s_reg.wait_cnt >= s_reg.dec_a && s_reg.wait_cnt >= s_reg.dec_b
                     |=> s_reg.wait_cnt == $past(s_reg.wait_cnt)
                         - ($past(op.wait_decrement_choice) ? $past(s_reg.dec_b)
                                                            : $past(s_reg.dec_a)))
    else $error("wait count not reduced by the chosen amount");

  a_hold_freezes:
    assert property (s_reg.host_access_hold && s_reg.state != fsir_pkg::ST_BUSY && !freset
                     |=> $stable(s_reg.pc))
    else $error("sequencer moved while host hold was set");

  a_busy_waits:
    assert property (s_reg.state == fsir_pkg::ST_BUSY && !fir_done_i && !freset
                     |=> $stable(s_reg.pc) && s_reg.state == fsir_pkg::ST_BUSY)
    else $error("step pointer moved before the filter finished");

endmodule
`default_nettype wire

// ==== hdl/fsir_cfg.svh ====
// constants for the filter sequencer instruction memory
//
// Summary of operation
// - program holds up to 32 steps: filter, wait, jump, loop load or no-op
// - each step is one 128-bit word of conditions, filter parameters, routing
// - only step bits 8:0 are the operation; upper bits are parameters or preload
// - bits outside the decoded operation type are ignored
// - address holds channel on top, step in middle, quarter in bits 3:2
// - memory reads and writes act only while the host hold bit is set
// - filter reset puts step pointer at 31 so execution wraps to step 0
// - filter reset initialises data read and write pointers; software applies it
// - fixed read offset added to one chosen filter step; writes unchanged
// - bits 8:7: 00 wait, 01 filter, bit 8 set is jump
// - no-op and loop load are filter-type steps, not separate opcodes
// - jump: bits 7:3 destination step, bits 2:0 condition code
// - conditions: 000 below threshold, 001 at/above, 010 loop nonzero, 011 zero
// - resampler step flag advances resampler at start or each output, host chosen
// - decrement choice selects between two programmable wait decrement amounts
// - decrement enable lowers wait count when the step begins
// - loop preload flag loads loop counter from bits 20:9; start stays clear
`ifndef FSIR_CFG_SVH
`define FSIR_CFG_SVH
`define FSIR_PC_W        5
`define FSIR_LAST_STEP   5'h1F
`define FSIR_WORD_W      128
`define FSIR_PARAM_W     119
`define FSIR_LOOP_LSB    9
`define FSIR_LOOP_W      12
`define FSIR_WAIT_W      10
`define FSIR_OFF_W       8
`define FSIR_ADR_W       18
`define FSIR_REGION_REGS 5'h00
`define FSIR_REGION_MEM  5'h02
`define FSIR_REG_CTRL    7'h00
`define FSIR_REG_THRESH  7'h01
`define FSIR_REG_DECR    7'h02
`define FSIR_REG_OFFSET  7'h03
`define FSIR_REG_FRESET  7'h04
`define FSIR_REG_STATUS  7'h05
`define FSIR_REG_LOOP    7'h06
`define FSIR_CTRL_HOLD   0
`define FSIR_CTRL_RSMODE 1
`define FSIR_CTRL_SYNC   2
`define FSIR_CC_BELOW    3'h0
`define FSIR_CC_ATLEAST  3'h1
`define FSIR_CC_LOOPNZ   3'h2
`define FSIR_CC_LOOPZ    3'h3
`define FSIR_CC_NORSCO   3'h4
`define FSIR_CC_RESAMPLER_CARRY_OUT     3'h5
`define FSIR_CC_SYNC     3'h6
`define FSIR_CC_ALWAYS   3'h7
`endif

// ==== hdl/fsir_pkg.sv ====
// types of the filter sequencer instruction memory
package fsir_pkg;
  typedef enum logic [2:0] {ST_PRIME = 3'b001, ST_RUN = 3'b010, ST_BUSY = 3'b100} fsir_state_type;
  typedef enum logic [2:0] {K_WAIT = 3'b001, K_FIR = 3'b010, K_JUMP = 3'b100} fsir_kind_type;
  typedef struct packed {
    fsir_kind_type kind;
    logic [2:0]    condition_select;
    logic [4:0]    jump_target_field;
    logic          start;
    logic          resampler_step_flag;
    logic          wait_decrement_choice;
    logic          wait_decrement_enable;
    logic          loop_preload_flag;
    logic          loop_decrement_flag;
    logic          rotation_counter_enable;
  } fsir_op_type;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [17:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } fsir_wb_req_type;
  typedef struct packed {
    logic         start;
    logic         rotation_counter_enable;
    logic [7:0]   read_offset;
    logic [118:0] param;
  } fsir_fir_cmd_type;
  typedef struct packed {
    fsir_state_type state;
    logic [4:0]     pc;
    logic [9:0]     wait_cnt;
    logic [11:0]    loop_cnt;
    logic           host_access_hold;
    logic           rs_mode;
    logic           sync_bit;
    logic [9:0]     thresh;
    logic [9:0]     dec_a;
    logic [9:0]     dec_b;
    logic [4:0]     off_step;
    logic [7:0]     off_val;
    logic           off_en;
    logic           ack;
    logic [31:0]    rdat;
    logic           rs_step;
    logic           rs_arm;
    logic           ptr_rst;
    fsir_fir_cmd_type cmd;
  } fsir_regs_type;
endpackage

// ==== hdl/fsir_op_decode.sv ====
// decoder of the nine-bit sequencer operation
`timescale 1ns/100ps
`default_nettype none
module fsir_op_decode
(
  // operation field
  input  wire logic [8:0]          op_i,
  // decoded operation
  output fsir_pkg::fsir_op_type    dec_o
);
  always_comb
  begin
    dec_o = '0;
    dec_o.condition_select = op_i[2:0];
    dec_o.jump_target_field = op_i[7:3];
    if (op_i[8])
    begin
      dec_o.kind = fsir_pkg::K_JUMP;
    end
    else if (op_i[7])
    begin
      // no-op and loop load are this type with start clear
      dec_o.kind = fsir_pkg::K_FIR;
      dec_o.start = op_i[6];
      dec_o.resampler_step_flag = op_i[5];
      dec_o.wait_decrement_choice = op_i[4];
      dec_o.wait_decrement_enable = op_i[3];
      dec_o.loop_preload_flag = op_i[2];
      dec_o.loop_decrement_flag = op_i[1];
      dec_o.rotation_counter_enable = op_i[0];
    end
    else
    begin
      dec_o.kind = fsir_pkg::K_WAIT;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/fsir_cond.sv ====
// condition code evaluation for wait and jump steps
`timescale 1ns/100ps
`default_nettype none
`include "fsir_cfg.svh"
module fsir_cond
(
  // selection
  input  wire logic [2:0]  sel_i,
  // operands
  input  wire logic [9:0]  wait_cnt_i,
  input  wire logic [9:0]  thresh_i,
  input  wire logic [11:0] loop_cnt_i,
  input  wire logic        rs_carry_i,
  input  wire logic        sync_i,
  // result
  output logic             true_o
);
  always_comb
  begin
    unique case (sel_i)
      `FSIR_CC_BELOW:   true_o = !(wait_cnt_i >= thresh_i);
      `FSIR_CC_ATLEAST: true_o = wait_cnt_i >= thresh_i;
      `FSIR_CC_LOOPNZ:  true_o = loop_cnt_i != 12'h000;
      `FSIR_CC_LOOPZ:   true_o = loop_cnt_i == 12'h000;
      `FSIR_CC_NORSCO:  true_o = !rs_carry_i;
      `FSIR_CC_RESAMPLER_CARRY_OUT:    true_o = rs_carry_i;
      `FSIR_CC_SYNC:    true_o = sync_i;
      `FSIR_CC_ALWAYS:  true_o = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// ==== verification/fsir_engine_model.sv ====
// compute engine stand-in that answers started filters
`timescale 1ns/100ps
`default_nettype none
module fsir_engine_model
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       start_i,
  input  wire logic [3:0] lat_i,
  // answers
  output logic            out_o,
  output logic            done_o
);
  logic [3:0] cnt_reg;

  // one output pulse, then done one cycle later
  always_ff @(posedge clk_i)
  begin
    out_o  <= 1'b0;
    done_o <= 1'b0;
    if (rst_i)
      cnt_reg <= 4'h0;
    else if (start_i)
      cnt_reg <= lat_i;
    else if (cnt_reg != 4'h0)
    begin
      cnt_reg <= cnt_reg - 4'h1;
      out_o   <= (cnt_reg == 4'h2);
      done_o  <= (cnt_reg == 4'h1);
    end
  end
endmodule
`default_nettype wire

// ==== verification/fsir_seq_tb.sv ====
// self-checking bench of the filter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "fsir_cfg.svh"
module fsir_seq_tb;
  localparam int LOOPS = 3;
  logic                       clk_i, rst_i, sample_i, carry, rs_step, ptr_rst;
  logic                       wb_ack_o, fir_out, fir_done, got_rs, got_rot;
  fsir_pkg::fsir_wb_req_type  wb_req;
  fsir_pkg::fsir_fir_cmd_type fir_cmd_o;
  logic [31:0]                wb_dat_o, seed, rd;
  logic [4:0]                 step_o, prev;
  logic [3:0]                 lat;
  logic [9:0]                 thr;
  logic [7:0]                 off, got_off;
  logic [118:0]               got_param;
  logic [127:0]               prog [7];
  int                         miscompares, tests_run, visits, starts, ptr_pulses, rs_cnt, n;

  fsir_seq DUT
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .sample_i(sample_i), .fir_output_i(fir_out),
    .fir_done_i(fir_done), .resampler_carry_out_i(carry), .fir_cmd_o(fir_cmd_o),
    .resampler_step_o(rs_step), .data_ptr_reset_o(ptr_rst), .step_o(step_o)
  );

  fsir_engine_model engine
  (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(fir_cmd_o.start), .lat_i(lat),
    .out_o(fir_out), .done_o(fir_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [17:0] reg_adr(input logic [6:0] i);
    return {4'h0, `FSIR_REGION_REGS, i, 2'b00};
  endfunction

  function automatic logic [17:0] mem_adr(input logic [4:0] s, input logic [1:0] q);
    return {4'h0, `FSIR_REGION_MEM, s, q, 2'b00};
  endfunction

  // program: wait, filter, preload, decrement, three jumps
  function automatic logic [8:0] op_of(input int s, input logic [3:0] r);
    case (s)
      0: return {2'b00, r, 3'b001};
      1: return {6'b011101, 2'b00, r[0]};
      2: return 9'b010000100;
      3: return 9'b010000010;
      4: return {1'b1, 5'h03, 3'b010};
      5: return {1'b1, 5'h06, 3'b011};
      default: return {1'b1, 5'h00, 3'b000};
    endcase
  endfunction

  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 50);
    chk("bus ack", wb_ack_o, 1'b1);
    rd = wb_dat_o;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
  endtask

  // one input sample every other cycle
  task automatic pulse_samples(input int cnt);
    repeat (cnt)
    begin
      @(posedge clk_i);
      sample_i <= 1'b1;
      @(posedge clk_i);
      sample_i <= 1'b0;
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
    carry <= ~carry;

  // watch the outputs where they are settled
  always @(negedge clk_i)
  begin
    if (!rst_i && ptr_rst === 1'b1)
      ptr_pulses++;
    if (rs_step === 1'b1)
      rs_cnt++;
    if (step_o === 5'h03 && prev !== 5'h03)
      visits++;
    prev = step_o;
    if (fir_cmd_o.start === 1'b1)
    begin
      starts++;
      got_param = fir_cmd_o.param;
      got_off   = fir_cmd_o.read_offset;
      got_rot   = fir_cmd_o.rotation_counter_enable;
      got_rs    = rs_step;
    end
  end

  initial
  begin
    #500000;
    miscompares++;
    test_done;
  end

  initial
  begin
    seed = 32'd97;
    {rst_i, sample_i, carry, wb_req, lat, prev} = '0;
    rst_i = 1'b1;
    {miscompares, tests_run, visits, starts, ptr_pulses, rs_cnt} = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("step after reset", step_o, 5'h1F);
    chk("pointer reset pulse", ptr_rst, 1'b1);
    $display("test reset done");
    thr = 10'(2 + rnd() % 6);
    off = 8'(rnd());
    lat <= 4'(2 + rnd() % 8);
    wb(1'b1, reg_adr(`FSIR_REG_CTRL), 32'h1);
    wb(1'b1, mem_adr(5'h00, 2'h0), 32'hA5A50001);
    wb(1'b1, reg_adr(`FSIR_REG_CTRL), 32'h0);
    wb(1'b1, mem_adr(5'h00, 2'h0), 32'h0000FFFF);
    wb(1'b0, mem_adr(5'h00, 2'h0), 32'h0);
    chk("read without hold", rd, 32'h0);
    wb(1'b1, reg_adr(`FSIR_REG_CTRL), 32'h1);
    wb(1'b0, mem_adr(5'h00, 2'h0), 32'h0);
    chk("write without hold", rd, 32'hA5A50001);
    wb(1'b0, {4'h1, `FSIR_REGION_MEM, 5'h00, 2'h0, 2'b00}, 32'h0);
    chk("other channel", rd, 32'h0);
    $display("test hold done");
    for (int s = 0; s < 7; s++)
    begin
      prog[s] = {rnd(), rnd(), rnd(), rnd()};
      rd = rnd();
      prog[s][8:0] = op_of(s, rd[3:0]);
    end
    prog[2][20:9] = 12'(LOOPS);
    for (int s = 0; s < 7; s++)
      for (int q = 0; q < 4; q++)
        wb(1'b1, mem_adr(5'(s), 2'(q)), prog[s][32*q +: 32]);
    for (int s = 0; s < 7; s++)
      for (int q = 0; q < 4; q++)
      begin
        wb(1'b0, mem_adr(5'(s), 2'(q)), 32'h0);
        chk("step quarter", rd, prog[s][32*q +: 32]);
      end
    $display("test load done");
    wb(1'b1, reg_adr(`FSIR_REG_THRESH), {22'h0, thr});
    wb(1'b1, reg_adr(`FSIR_REG_DECR), {22'h0, thr});
    wb(1'b1, reg_adr(`FSIR_REG_OFFSET), {1'b1, 15'h0, off, 3'h0, 5'h01});
    wb(1'b1, reg_adr(`FSIR_REG_FRESET), 32'h1);
    repeat (3) @(negedge clk_i);
    chk("step after filter reset", step_o, 5'h1F);
    chk("pointer reset count", ptr_pulses, 2);
    wb(1'b1, reg_adr(`FSIR_REG_CTRL), 32'h0);
    repeat (10) @(negedge clk_i);
    chk("stalled wait", step_o, 5'h00);
    pulse_samples(thr);
    for (n = 0; n < 100 && starts == 0; n++)
      @(negedge clk_i);
    chk("filter parameters", got_param, prog[1][127:9]);
    chk("read offset", got_off, off);
    chk("rotation flag", got_rot, prog[1][0]);
    chk("resampler at start", got_rs, 1'b1);
    for (n = 0; n < 300 && !(visits >= LOOPS && step_o === 5'h00); n++)
      @(negedge clk_i);
    chk("loop passes", visits, LOOPS);
    chk("filter starts", starts, 1);
    chk("resampler steps", rs_cnt, 1);
    chk("back at wait", step_o, 5'h00);
    $display("test program done");
    // resampler now steps on each filter output instead of at start
    wb(1'b1, reg_adr(`FSIR_REG_CTRL), 32'h2);
    pulse_samples(thr);
    for (n = 0; n < 100 && starts < 2; n++)
      @(negedge clk_i);
    chk("no resampler at start", got_rs, 1'b0);
    for (n = 0; n < 300 && !(visits >= 2 * LOOPS && step_o === 5'h00); n++)
      @(negedge clk_i);
    chk("second loop passes", visits, 2 * LOOPS);
    chk("second filter start", starts, 2);
    chk("resampler per output", rs_cnt, 2);
    wb(1'b0, reg_adr(`FSIR_REG_STATUS), 32'h0);
    chk("wait count", rd[25:16], 10'h0);
    wb(1'b0, reg_adr(`FSIR_REG_LOOP), 32'h0);
    chk("loop counter", rd[11:0], 12'h0);
    $display("test resampler mode done");
    test_done;
  end
endmodule
`default_nettype wire
